// >>> hw/aao_top.v
// The implementer's own choices: the APB slave port and the placing of the registers.
`include "aao_defs.vh"

// APB-controlled datapath: software loads the working register, issues an
// operation with a memory operand on mem_rdata, and a memory write is pulsed
// out when the destination is memory.
module aao_top #(
  parameter W = 8
) (
  // Clock, reset, enable.
  input  wire                   pclk,
  input  wire                   presetn,
  input  wire                   clk_en,
  // APB slave.
  input  wire                   psel,
  input  wire                   penable,
  input  wire                   pwrite,
  input  wire [`AAO_ADDR_W-1:0] paddr,
  input  wire [31:0]            pwdata,
  output reg  [31:0]            prdata,
  output wire                   pready,
  output wire                   pslverr,
  // Data memory operand and write-back.
  input  wire [W-1:0]           mem_rdata,
  output reg  [W-1:0]           mem_wdata_q,
  output reg                    mem_we_q
);

  reg  [W-1:0]         wreg_q;
  reg  [W-1:0]         result_q;
  reg  [3:0]           flags_q;
  wire                 acc_w;
  wire                 wr_w;
  wire                 go_w;
  wire [`AAO_OP_W-1:0] op_w;
  wire [W-1:0]         res_w;
  wire                 to_mem_w;
  wire [3:0]           fwe_w;
  wire [3:0]           fval_w;
  reg                  hit_w;

  ////////////////////////////////////////////////////////////////////////////
  // Zero-wait APB; unmapped offsets answer with pslverr.
  assign pready  = 1'b1;
  assign acc_w   = psel && penable && clk_en;
  assign wr_w    = acc_w && pwrite;
  assign go_w    = wr_w && (paddr == `AAO_REG_CTRL) && pwdata[`AAO_CTRL_GO];
  assign op_w    = pwdata[`AAO_CTRL_OP_HI:`AAO_CTRL_OP_LO];
  assign pslverr = psel && penable && !hit_w;

  always @*
  begin
    hit_w  = 1'b1;
    prdata = 32'h0000_0000;
    case (paddr)
      `AAO_REG_CTRL:   prdata = 32'h0000_0000;
      `AAO_REG_WREG:   prdata = {{(32-W){1'b0}}, wreg_q};
      `AAO_REG_FLAGS:  prdata = {27'h0, mem_we_q, flags_q};
      `AAO_REG_RESULT: prdata = {{(32-W){1'b0}}, result_q};
      default:         hit_w  = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  aao_alu #(
    .W (W)
  ) u_alu (
    .op       (op_w),
    .wreg     (wreg_q),
    .mem      (mem_rdata),
    .imm      (pwdata[`AAO_CTRL_IMM_HI:`AAO_CTRL_IMM_LO]),
    .mem_op   (pwdata[`AAO_CTRL_MEMOP]),
    .result   (res_w),
    .to_mem   (to_mem_w),
    .flag_we  (fwe_w),
    .flag_val (fval_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // The memory operand is sampled in the access cycle of the control write,
  // so the memory must present the addressed byte by then.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wreg_q      <= `AAO_RST_BYTE;
      result_q    <= `AAO_RST_BYTE;
      flags_q     <= `AAO_RST_FLAGS;
      mem_wdata_q <= `AAO_RST_BYTE;
      mem_we_q    <= 1'b0;
    end
    else if (clk_en)
    begin
      mem_we_q <= 1'b0;
      if (wr_w && (paddr == `AAO_REG_WREG))
      begin
        wreg_q <= pwdata[W-1:0];
      end
      if (wr_w && (paddr == `AAO_REG_FLAGS))
      begin
        flags_q <= pwdata[3:0];
      end
      if (go_w && (op_w != `AAO_OP_NOP))
      begin
        result_q <= res_w;
        flags_q  <= (flags_q & ~fwe_w) | (fval_w & fwe_w);
        if (to_mem_w)
        begin
          mem_wdata_q <= res_w;
          mem_we_q    <= 1'b1;
        end
        else
        begin
          wreg_q <= res_w;
        end
      end
    end
  end

endmodule

// >>> pkg/aao_defs.vh
// Notes on behaviour
// - Add into memory sums the working register and the addressed memory byte.
// - Add into memory writes its sum back to memory, not the working register.
// - AND memory to working forms working register AND memory byte, bit by bit.
// - Both AND-to-working operations load the working register; memory stays unchanged.
// - AND immediate to working ANDs the working register with the instruction constant.
// - AND into memory forms memory byte AND working register, bitwise.
`ifndef AAO_DEFS_VH
`define AAO_DEFS_VH

////////////////////////////////////////////////////////////////////////////////
// Operation codes.
`define AAO_OP_W        2
`define AAO_OP_NOP      2'h0
`define AAO_OP_ADD_INTO_MEMORY     2'h1
`define AAO_OP_AND_MEM  2'h2
`define AAO_OP_AND_IMM  2'h3

////////////////////////////////////////////////////////////////////////////////
// APB register byte offsets.
`define AAO_ADDR_W      8
`define AAO_REG_CTRL    8'h00
`define AAO_REG_WREG    8'h04
`define AAO_REG_FLAGS   8'h08
`define AAO_REG_RESULT  8'h0C

// Control register fields.
`define AAO_CTRL_GO     8
`define AAO_CTRL_IMM_LO 0
`define AAO_CTRL_IMM_HI 7
`define AAO_CTRL_OP_LO  12
`define AAO_CTRL_OP_HI  13
`define AAO_CTRL_MEMOP  14

// Flag register bit positions.
`define AAO_FLAG_C      0
`define AAO_FLAG_HC     1
`define AAO_FLAG_Z      2
`define AAO_FLAG_OV     3
`define AAO_FLAG_MW     4

// Reset values.
`define AAO_RST_BYTE    8'h00
`define AAO_RST_FLAGS   4'h0

`endif

// >>> hw/aao_alu.v
`include "aao_defs.vh"

// Combinational arithmetic and logic core for the operation group.
module aao_alu #(
  parameter W = 8
) (
  // Operation select and operands.
  input  wire [`AAO_OP_W-1:0] op,
  input  wire [W-1:0]         wreg,
  input  wire [W-1:0]         mem,
  input  wire [W-1:0]         imm,
  input  wire                 mem_op,
  // Results.
  output reg  [W-1:0]         result,
  output reg                  to_mem,
  output reg  [3:0]           flag_we,
  output wire [3:0]           flag_val
);

  wire [W:0]   sum_w;
  wire [4:0]   nib_w;
  wire         ov_w;

  assign sum_w = {1'b0, wreg} + {1'b0, mem};
  assign nib_w = {1'b0, wreg[3:0]} + {1'b0, mem[3:0]};
  assign ov_w  = (wreg[W-1] == mem[W-1]) && (sum_w[W-1] != wreg[W-1]);

  // Flag values line up with the flag bit positions.
  assign flag_val = {ov_w, (result == {W{1'b0}}), nib_w[4], sum_w[W]};

  always @*
  begin
    result  = {W{1'b0}};
    to_mem  = 1'b0;
    flag_we = 4'h0;
    case (op)
      `AAO_OP_ADD_INTO_MEMORY:
      begin
        result  = sum_w[W-1:0];
        to_mem  = 1'b1;
        flag_we = 4'hF;
      end
      `AAO_OP_AND_MEM:
      begin
        // AND with memory, same product for the memory-destination form
        result  = wreg & mem;
        to_mem  = mem_op;
        flag_we = 4'h4;
      end
      `AAO_OP_AND_IMM:
      begin
        result  = wreg & imm;
        flag_we = 4'h4;
      end
      default:
      begin
        result  = {W{1'b0}};
      end
    endcase
  end

endmodule

// >>> test/aao_props.sv
module aao_props #(parameter W = 8) (
  // Clock and APB.
  input logic pclk,
  input logic presetn,
  input logic clk_en,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  // Memory side.
  input logic [W-1:0] mem_rdata,
  input logic [W-1:0] mem_wdata_q,
  input logic mem_we_q
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadow copies let read data be judged without seeing inside the block.
  logic ac, rd, go, md, z_q;
  logic [1:0] op;
  logic [W-1:0] e_d, e_q, w_q;
  assign ac = psel & penable & clk_en;
  assign rd = ac & !pwrite;
  assign op = pwdata[13:12];
  assign go = ac & pwrite & paddr == 8'h00 & pwdata[8] & |op;
  assign md = op == 2'h1 | op == 2'h2 & pwdata[14];
  assign e_d = op == 2'h1 ? w_q + mem_rdata : w_q & (op == 2'h3 ? pwdata[W-1:0] : mem_rdata);
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      w_q <= '0;
      e_q <= '0;
      z_q <= 1'b0;
    end
    else if (ac & pwrite & paddr == 8'h04)
      w_q <= pwdata[W-1:0];
    else if (ac & pwrite & paddr == 8'h08)
      z_q <= pwdata[2];
    else if (go)
    begin
      e_q <= e_d;
      z_q <= e_d == '0;
      if (!md)
        w_q <= e_d;
    end
  ////////////////////////////////////////
  sequence s_go(o, d);
    go && op == o && md == d;
  endsequence
  property p_sum; s_go(2'h1, 1'b1) |=> mem_wdata_q == e_q; endproperty
  a_sum: assert property (p_sum) else $error("sum");
  property p_mdst; s_go(2'h1, 1'b1) |=> mem_we_q; endproperty
  a_mdst: assert property (p_mdst) else $error("dest");
  property p_wreg; rd && paddr == 8'h04 |-> prdata[W-1:0] == w_q; endproperty
  a_wreg: assert property (p_wreg) else $error("wreg");
  property p_keep; go && !md |=> !mem_we_q; endproperty
  a_keep: assert property (p_keep) else $error("keep");
  property p_res; rd && paddr == 8'h0C |-> prdata[W-1:0] == e_q; endproperty
  a_res: assert property (p_res) else $error("res");
  property p_and_into_memory; s_go(2'h2, 1'b1) |=> mem_we_q && mem_wdata_q == e_q; endproperty
  a_and_into_memory: assert property (p_and_into_memory) else $error("and_into_memory");
  property p_zero; rd && paddr == 8'h08 |-> prdata[2] == z_q; endproperty
  a_zero: assert property (p_zero) else $error("zero");
endmodule
bind aao_top aao_props #(.W(W)) u_props (.pclk, .presetn, .clk_en, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .mem_rdata, .mem_wdata_q, .mem_we_q);

// >>> test/test_aao_top.sv
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_total++; \
  $display("[ERR] %0t %h %h", $time, a, e); end end
module test_aao_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
  logic        pready, pslverr, mem_we_q, we, se, ce = 1'b1;
  logic [7:0]  paddr = '0, mem_rdata = '0, mem_wdata_q, wd;
  logic [31:0] pwdata = '0, prdata, rd;
  int          err_total = 0, comparisons = 0;
  always #5 pclk = ~pclk;
  aao_top dut (.pclk, .presetn, .clk_en(ce), .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .mem_rdata, .mem_wdata_q, .mem_we_q);
  ////////////////////////////////////////
  task automatic complete_run;
    if (err_total == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // The idle edge at the end keeps two transfers from driving psel in one step.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      err_total++;
      complete_run;
    end
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
    we = mem_we_q;
    wd = mem_wdata_q;
    @(posedge pclk);
  endtask
  task automatic op(input logic [7:0] w, m, input logic [31:0] c, input logic [7:0] r,
                    input logic mw, input logic [7:0] ew, input logic [4:0] f);
    mem_rdata <= m;
    apb(1'b1, 8'h04, {24'h0, w});
    apb(1'b1, 8'h00, c);
    `CHK({we, mw ? wd : r}, {mw, r})
    apb(1'b0, 8'h0C, 32'h0);
    `CHK(rd[7:0], r)
    apb(1'b0, 8'h04, 32'h0);
    `CHK(rd[7:0], ew)
    apb(1'b0, 8'h08, 32'h0);
    `CHK(rd[4:0], f)
  endtask
  task automatic t_add;
    op(8'h8F, 8'h91, 32'h1100, 8'h20, 1'b1, 8'h8F, 5'h0B);
    op(8'h01, 8'hFF, 32'h1100, 8'h00, 1'b1, 8'h01, 5'h07);
  endtask
  task automatic t_and;
    op(8'hF0, 8'h3C, 32'h2100, 8'h30, 1'b0, 8'h30, 5'h03);
    op(8'h30, 8'hFF, 32'h310F, 8'h00, 1'b0, 8'h00, 5'h07);
    op(8'hAA, 8'h6C, 32'h6100, 8'h28, 1'b1, 8'hAA, 5'h03);
  endtask
  task automatic t_refuse;
    apb(1'b1, 8'h00, 32'h1000);
    apb(1'b1, 8'h10, 32'h0);
    `CHK({we, se}, 2'b01)
  endtask
  // A write to the working register while the enable is low must leave it as it was.
  task automatic t_hold;
    ce <= 1'b0;
    apb(1'b1, 8'h04, 32'h5A);
    ce <= 1'b1;
    apb(1'b0, 8'h04, 32'h0);
    `CHK(rd[7:0], 8'hAA)
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h04, 32'h0);
    `CHK(rd[7:0], 8'h00)
  endtask
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_add;
    t_and;
    t_refuse;
    t_hold;
    complete_run;
  end
endmodule
